//--- if_frequency_counter_gate_tb.sv
// Self-checking bench for the gated IF counter.
// Assumes ifc_pkg, ifc_presc_if, ifc_prescaler and ifc_counter are compiled first.
`timescale 1ns/10ps
module if_frequency_counter_gate_tb;
  localparam int US_FINE = 100;
  localparam int US_MID = 40;
  localparam int US_COARSE = 5;
  logic clk, reset, ce, zero_span_sel, measure_start;
  logic [2:0] resolution_sel;
  logic ref_10m, bus_clock_4m, count_mode_input, irq_acknowledge;
  logic prescaler_read_n, timer_select_n, timer_read_n;
  logic gate_pulse_out, overflow_irq, count_done_irq, measure_busy, host_data_bus_oe_n;
  logic [ifc_pkg::DATA_W-1:0] host_data_bus_out;
  logic gate_high_out;
  logic [7:0] exp_q[$];
  logic prev_oe_n;
  int err_count, n_compared;

  ifc_counter #(.GATE_US_FINE(US_FINE), .GATE_US_MID(US_MID), .GATE_US_COARSE(US_COARSE))
  u_ifc_counter (.clk(clk), .reset(reset), .ce(ce), .ref_10m(ref_10m),
    .bus_clock_4m(bus_clock_4m), .count_mode_input(count_mode_input),
    .zero_span_sel(zero_span_sel), .resolution_sel(resolution_sel),
    .measure_start(measure_start), .irq_acknowledge(irq_acknowledge),
    .prescaler_read_n(prescaler_read_n), .timer_select_n(timer_select_n),
    .timer_read_n(timer_read_n), .gate_pulse_out(gate_pulse_out),
    .overflow_irq(overflow_irq), .count_done_irq(count_done_irq),
    .measure_busy(measure_busy), .host_data_bus_out(host_data_bus_out),
    .host_data_bus_oe_n(host_data_bus_oe_n));

  // Active-high gate variant on the same stimulus
  ifc_counter #(.GATE_US_FINE(US_FINE), .GATE_US_MID(US_MID), .GATE_US_COARSE(US_COARSE),
    .GATE_ACTIVE_HIGH(1'b1))
  u_ifc_counter_high (.clk(clk), .reset(reset), .ce(ce), .ref_10m(ref_10m),
    .bus_clock_4m(bus_clock_4m), .count_mode_input(count_mode_input),
    .zero_span_sel(zero_span_sel), .resolution_sel(resolution_sel),
    .measure_start(measure_start), .irq_acknowledge(irq_acknowledge),
    .prescaler_read_n(prescaler_read_n), .timer_select_n(timer_select_n),
    .timer_read_n(timer_read_n), .gate_pulse_out(gate_high_out),
    .overflow_irq(), .count_done_irq(), .measure_busy(), .host_data_bus_out(),
    .host_data_bus_oe_n());

  ifc_host_model u_ifc_host_model (.clk(clk), .ref_10m(ref_10m),
    .bus_clock_4m(bus_clock_4m), .count_mode_input(count_mode_input),
    .irq_acknowledge(irq_acknowledge), .prescaler_read_n(prescaler_read_n),
    .timer_select_n(timer_select_n), .timer_read_n(timer_read_n));

  // ****************************************
  // Checking
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    if (exp_q.size() != 0) check("reads answered", exp_q.size(), 0);
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Oldest noted byte against each new bus drive
  always @(negedge clk) begin
    prev_oe_n <= host_data_bus_oe_n;
    if (prev_oe_n === 1'b1 && host_data_bus_oe_n === 1'b0) begin
      if (exp_q.size() == 0) check("bus unexpected", 1, 0);
      else check("bus data", host_data_bus_out, exp_q.pop_front());
    end
  end

  // ****************************************
  // One gated measurement and its readout
  // ****************************************
  task automatic measure(input logic zs, input logic [2:0] res, input logic ack);
    int us, len, n, k;
    us = (res == 3'h0) ? US_FINE : (res == 3'h1) ? US_MID : US_COARSE;
    k = $urandom_range(us * 50 / 6 - 10, 1);
    len = 0;
    n = 0;
    zero_span_sel = zs;
    resolution_sel = res;
    u_ifc_host_model.acknowledge(ack);
    measure_start = 1'b1;
    @(negedge clk) measure_start = 1'b0;
    while (gate_pulse_out !== 1'b0 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 3000) begin
      err_count++;
      complete_run();
    end
    check("busy in gate", measure_busy, 1'b1);
    check("gate high variant", gate_high_out, 1'b1);
    fork
      while (gate_pulse_out === 1'b0 && len < 20000) begin
        @(negedge clk);
        len++;
      end
      begin
        repeat (4) @(negedge clk);
        u_ifc_host_model.pulse_if(k);
      end
    join
    if (len >= 20000) begin
      err_count++;
      complete_run();
    end
    check("gate length", (len + 25) / 50, us);
    repeat (3) @(negedge clk);
    check("gate idle", gate_pulse_out, 1'b1);
    check("gate high idle", gate_high_out, 1'b0);
    check("busy after gate", measure_busy, 1'b0);
    check("done irq", count_done_irq, ack);
    check("overflow irq", overflow_irq, 1'b0);
    exp_q.push_back(k[7:0]);
    u_ifc_host_model.host_read(1'b0);
    exp_q.push_back(k[15:8]);
    u_ifc_host_model.host_read(1'b1);
    exp_q.push_back(8'h00);
    u_ifc_host_model.host_read(1'b1);
    u_ifc_host_model.acknowledge(1'b0);
    repeat (4) @(negedge clk);
    check("done irq cleared", count_done_irq, 1'b0);
    $display("test done res %0d zero span %0b count %0d", res, zs, k);
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    #2000000;
    err_count++;
    complete_run();
  end

  initial begin
    reset = 1'b1;
    ce = 1'b1;
    zero_span_sel = 1'b0;
    resolution_sel = 3'h0;
    measure_start = 1'b0;
    prev_oe_n = 1'b1;
    err_count = 0;
    n_compared = 0;
    void'($urandom(73574));
    repeat (5) @(posedge clk);
    @(negedge clk) reset = 1'b0;
    // Bus clock idle, so only the prescaled reference can time the gate
    u_ifc_host_model.bus_on = 1'b0;
    for (int r = 0; r < 6; r++) measure(1'b0, r[2:0], 1'b1);
    measure(1'b0, 3'h2, 1'b0);
    // Clock enable low: a start must not be taken
    @(negedge clk) ce = 1'b0;
    measure_start = 1'b1;
    repeat (5) @(negedge clk);
    check("frozen start", measure_busy, 1'b0);
    check("frozen gate", gate_pulse_out, 1'b1);
    measure_start = 1'b0;
    ce = 1'b1;
    repeat (3) @(negedge clk);
    check("start after freeze", measure_busy, 1'b0);
    $display("test done clock enable freeze");
    // Reference idle, so only the bus clock can time the gate
    u_ifc_host_model.ref_on = 1'b0;
    u_ifc_host_model.bus_on = 1'b1;
    measure(1'b1, 3'h1, 1'b1);
    measure(1'b1, 3'h4, 1'b1);
    complete_run();
  end
endmodule // if_frequency_counter_gate_tb

//--- ifc_counter.sv
// Gated IF frequency counter: timebase, gate timer, prescaler, count timer, host reads.
// Assumes pin inputs are asynchronous; zero_span_sel, resolution_sel and measure_start
// come from logic on clk.
`timescale 1ns/10ps
module ifc_counter #(
  parameter int GATE_US_FINE = ifc_pkg::GATE_US_10HZ,
  parameter int GATE_US_MID = ifc_pkg::GATE_US_100HZ,
  parameter int GATE_US_COARSE = ifc_pkg::GATE_US_1KHZ,
  parameter logic GATE_ACTIVE_HIGH = 1'b0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic ref_10m,
  input wire logic bus_clock_4m,
  input wire logic count_mode_input,
  input wire logic zero_span_sel,
  input wire logic [2:0] resolution_sel,
  input wire logic measure_start,
  input wire logic irq_acknowledge,
  input wire logic prescaler_read_n,
  input wire logic timer_select_n,
  input wire logic timer_read_n,
  output logic gate_pulse_out,
  output logic overflow_irq,
  output logic count_done_irq,
  output logic measure_busy,
  output logic [ifc_pkg::DATA_W-1:0] host_data_bus_out,
  output logic host_data_bus_oe_n
);

  // ****************************************
  // Gate length in timebase ticks
  // ****************************************
  function automatic logic [ifc_pkg::TICK_W-1:0] gate_ticks(input logic [2:0] res,
                                                           input logic use_bus);
    int us;
    int mhz;
    us = GATE_US_COARSE;
    if (res == ifc_pkg::RES_10HZ) us = GATE_US_FINE;
    else if (res == ifc_pkg::RES_100HZ) us = GATE_US_MID;
    mhz = use_bus ? ifc_pkg::BUS_MHZ : ifc_pkg::TB_MHZ;
    return ifc_pkg::TICK_W'(us * mhz);
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [ifc_pkg::SY_W-1:0] sy1_q, sy2_q, sy3_q, sy_pins;

  assign sy_pins = {timer_read_n, timer_select_n, prescaler_read_n, irq_acknowledge,
                    count_mode_input, bus_clock_4m, ref_10m};

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sy1_q <= ifc_pkg::SY_RESET;
      sy2_q <= ifc_pkg::SY_RESET;
      sy3_q <= ifc_pkg::SY_RESET;
    end else if (ce) begin
      sy1_q <= sy_pins;
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
    end
  end

  logic ref_rise, bus_rise, cnt_rise, ack_s, presc_rd, timer_rd, timer_rd_end;
  assign ref_rise = sy2_q[ifc_pkg::SY_REF] & ~sy3_q[ifc_pkg::SY_REF];
  assign bus_rise = sy2_q[ifc_pkg::SY_BUSCLK] & ~sy3_q[ifc_pkg::SY_BUSCLK];
  assign cnt_rise = sy2_q[ifc_pkg::SY_COUNT] & ~sy3_q[ifc_pkg::SY_COUNT];
  assign ack_s = sy2_q[ifc_pkg::SY_ACK];
  assign presc_rd = ~sy2_q[ifc_pkg::SY_PRD_N];
  assign timer_rd = ~sy2_q[ifc_pkg::SY_TSEL_N] & ~sy2_q[ifc_pkg::SY_TRD_N];
  assign timer_rd_end = ~(~sy3_q[ifc_pkg::SY_TSEL_N] & ~sy3_q[ifc_pkg::SY_TRD_N]) ? 1'b0
                        : ~timer_rd;

  // ****************************************
  // Timebase and clock select
  // ****************************************
  logic [2:0] div_q, div_d;
  logic div_tick_q, div_tick_d, tick_q, tick_d;

  always_comb begin
    div_d = div_q;
    div_tick_d = 1'b0;
    if (ref_rise) begin
      if (div_q == ifc_pkg::REF_DIV - 3'h1) begin
        div_d = 3'h0;
        div_tick_d = 1'b1;
      end else begin
        div_d = div_q + 3'h1;
      end
    end
    tick_d = zero_span_sel ? bus_rise : div_tick_q;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_q <= 3'h0;
      div_tick_q <= 1'b0;
      tick_q <= 1'b0;
    end else if (ce) begin
      div_q <= div_d;
      div_tick_q <= div_tick_d;
      tick_q <= tick_d;
    end
  end

  // ****************************************
  // Gate controller (timer channel 2)
  // ****************************************
  ifc_pkg::ifc_state_type state_q, state_d;
  logic [ifc_pkg::TICK_W-1:0] len_q, len_d, tcnt_q, tcnt_d;
  logic gate_q, gate_d, busy_q, busy_d, done_evt;

  always_comb begin
    state_d = state_q;
    len_d = len_q;
    tcnt_d = tcnt_q;
    done_evt = 1'b0;
    unique case (state_q)
      ifc_pkg::IFC_IDLE: begin
        if (measure_start) begin
          len_d = gate_ticks(resolution_sel, zero_span_sel);
          state_d = ifc_pkg::IFC_CLEAR;
        end
      end
      ifc_pkg::IFC_CLEAR: begin
        tcnt_d = '0;
        if (tick_q) state_d = ifc_pkg::IFC_GATE;
      end
      ifc_pkg::IFC_GATE: begin
        if (tick_q) begin
          if (tcnt_q == len_q - 20'h1) begin
            state_d = ifc_pkg::IFC_IDLE;
            done_evt = 1'b1;
          end else begin
            tcnt_d = tcnt_q + 20'h1;
          end
        end
      end
      default: state_d = ifc_pkg::IFC_IDLE;
    endcase
    gate_d = (state_d == ifc_pkg::IFC_GATE) ~^ GATE_ACTIVE_HIGH;
    busy_d = (state_d != ifc_pkg::IFC_IDLE);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= ifc_pkg::IFC_IDLE;
      len_q <= '0;
      tcnt_q <= '0;
      gate_q <= ~GATE_ACTIVE_HIGH;
      busy_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      len_q <= len_d;
      tcnt_q <= tcnt_d;
      gate_q <= gate_d;
      busy_q <= busy_d;
    end
  end

  // ****************************************
  // Prescaler and count channel 0
  // ****************************************
  ifc_presc_if pif ();
  assign pif.clear = (state_q == ifc_pkg::IFC_CLEAR);
  assign pif.step = (state_q == ifc_pkg::IFC_GATE) & cnt_rise;

  ifc_prescaler u_presc (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .pif(pif)
  );

  logic [ifc_pkg::TIMER_W-1:0] ch0_q, ch0_d;
  logic ovf_q, ovf_d, done_q, done_d;

  always_comb begin
    ch0_d = ch0_q;
    ovf_d = ovf_q;
    if (pif.clear) begin
      ch0_d = '0;
      ovf_d = 1'b0;
    end else if (pif.carry) begin
      ch0_d = ch0_q + 16'h1;
      if (ch0_q == 16'hffff) ovf_d = 1'b1;
    end
    done_d = done_q;
    if (done_evt && ack_s) done_d = 1'b1;
    else if (!ack_s) done_d = 1'b0;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ch0_q <= '0;
      ovf_q <= 1'b0;
      done_q <= 1'b0;
    end else if (ce) begin
      ch0_q <= ch0_d;
      ovf_q <= ovf_d;
      done_q <= done_d;
    end
  end

  // ****************************************
  // Host data bus
  // ****************************************
  logic [ifc_pkg::DATA_W-1:0] data_q, data_d;
  logic oe_n_q, oe_n_d, msb_q, msb_d;

  always_comb begin
    data_d = '0;
    oe_n_d = 1'b1;
    msb_d = msb_q;
    if (pif.clear) msb_d = 1'b0;
    else if (timer_rd_end) msb_d = ~msb_q;
    if (presc_rd) begin
      data_d = pif.count;
      oe_n_d = 1'b0;
    end else if (timer_rd) begin
      data_d = msb_q ? ch0_q[15:8] : ch0_q[7:0];
      oe_n_d = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      data_q <= '0;
      oe_n_q <= 1'b1;
      msb_q <= 1'b0;
    end else if (ce) begin
      data_q <= data_d;
      oe_n_q <= oe_n_d;
      msb_q <= msb_d;
    end
  end

  assign gate_pulse_out = gate_q;
  assign overflow_irq = ovf_q;
  assign count_done_irq = done_q;
  assign measure_busy = busy_q;
  assign host_data_bus_out = data_q;
  assign host_data_bus_oe_n = oe_n_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset || !ce);

  a_start_clears: assert property (
    (state_q == ifc_pkg::IFC_IDLE) && measure_start
    |=> pif.clear ##1 (pif.count == 8'h00) && (ch0_q == 16'h0000))
    else $error("measurement did not clear the counters");
  a_div_spacing: assert property (div_tick_q |=> !div_tick_q [*8])
    else $error("timebase ticks too close");
  a_bus_select: assert property (zero_span_sel && bus_rise |=> tick_q)
    else $error("bus clock not selected");
  a_gate_level: assert property (
    (state_q == ifc_pkg::IFC_GATE) == (gate_pulse_out == GATE_ACTIVE_HIGH))
    else $error("gate level wrong");
  a_gate_coarse: assert property (
    (state_q == ifc_pkg::IFC_IDLE) && measure_start
    && (resolution_sel == ifc_pkg::RES_1MHZ) && !zero_span_sel
    |=> len_q == ifc_pkg::TICK_W'(GATE_US_COARSE * ifc_pkg::TB_MHZ))
    else $error("coarse gate length wrong");
  a_gate_fine: assert property (
    (state_q == ifc_pkg::IFC_IDLE) && measure_start
    && (resolution_sel == ifc_pkg::RES_10HZ) && !zero_span_sel
    |=> len_q == ifc_pkg::TICK_W'(GATE_US_FINE * ifc_pkg::TB_MHZ))
    else $error("fine gate length wrong");
  a_gate_end: assert property (
    (state_q == ifc_pkg::IFC_GATE) && tick_q
    && (tcnt_q == len_q - 20'h1) |=> (state_q == ifc_pkg::IFC_IDLE))
    else $error("gate did not end on count");
  a_count_frozen: assert property (
    (state_q == ifc_pkg::IFC_IDLE) |=> $stable(pif.count))
    else $error("prescaler moved outside gate");
  a_ch0_step: assert property (
    pif.carry && !pif.clear |=> ch0_q == $past(ch0_q) + 16'h1)
    else $error("channel zero missed a carry");
  a_ch0_hold: assert property (
    !pif.carry && !pif.clear |=> $stable(ch0_q))
    else $error("channel zero moved without a carry");
  a_ovf_set: assert property (
    pif.carry && !pif.clear && (ch0_q == 16'hffff) |=> overflow_irq)
    else $error("overflow not raised");
  a_ovf_sticky: assert property (overflow_irq && !pif.clear |=> overflow_irq)
    else $error("overflow dropped before next start");
  a_done_set: assert property (done_evt && ack_s |=> count_done_irq)
    else $error("done interrupt not raised");
  a_ack_clear: assert property (!ack_s |=> !count_done_irq)
    else $error("done interrupt not cleared");
  a_presc_read: assert property (
    presc_rd |=> !host_data_bus_oe_n && (host_data_bus_out == $past(pif.count)))
    else $error("prescaler read wrong");
  a_bus_release: assert property (
    !presc_rd && !timer_rd |=> host_data_bus_oe_n && (host_data_bus_out == 8'h00))
    else $error("bus not released");
  a_timer_read: assert property (timer_rd && !presc_rd |=> !host_data_bus_oe_n)
    else $error("timer read not driven");
  a_timer_toggle: assert property (
    timer_rd_end && !pif.clear |=> msb_q != $past(msb_q))
    else $error("timer byte pointer did not advance");

endmodule // ifc_counter

//--- ifc_host_model.sv
// Host CPU and signal sources facing the gated IF counter.
// Assumes clk is the 50 MHz system clock; host strobes change on its falling edge.
`timescale 1ns/10ps
module ifc_host_model (
  input wire logic clk,
  output logic ref_10m,
  output logic bus_clock_4m,
  output logic count_mode_input,
  output logic irq_acknowledge,
  output logic prescaler_read_n,
  output logic timer_select_n,
  output logic timer_read_n
);
  // ****************************************
  // Sources, each stands still when switched off
  // ****************************************
  logic ref_on = 1'b1;
  logic bus_on = 1'b1;

  initial begin
    ref_10m = 1'b0;
    #3;
    forever begin
      #50;
      if (ref_on) ref_10m = ~ref_10m;
    end
  end

  initial begin
    bus_clock_4m = 1'b0;
    #7;
    forever begin
      #125;
      if (bus_on) bus_clock_4m = ~bus_clock_4m;
    end
  end

  initial begin
    count_mode_input = 1'b0;
    irq_acknowledge = 1'b1;
    prescaler_read_n = 1'b1;
    timer_select_n = 1'b1;
    timer_read_n = 1'b1;
  end

  // Counted edges, three clocks high and three low
  task automatic pulse_if(input int n);
    repeat (n) begin
      @(negedge clk) count_mode_input = 1'b1;
      repeat (3) @(negedge clk);
      count_mode_input = 1'b0;
      repeat (2) @(negedge clk);
    end
  endtask

  task automatic host_read(input logic timer);
    @(negedge clk);
    if (timer) begin
      timer_select_n = 1'b0;
      timer_read_n = 1'b0;
    end else begin
      prescaler_read_n = 1'b0;
    end
    repeat (5) @(negedge clk);
    prescaler_read_n = 1'b1;
    timer_select_n = 1'b1;
    timer_read_n = 1'b1;
    repeat (5) @(negedge clk);
  endtask

  task automatic acknowledge(input logic level);
    @(negedge clk) irq_acknowledge = level;
  endtask
endmodule // ifc_host_model

//--- ifc_pkg.sv
// Constants for the gated IF frequency counter.
// Assumes a 50 MHz system clock; every pin input is synchronised in the top module.
// How it works
// - Reference divided by five gives timebase
// - Zero span selects 4 MHz bus clock
// - Channel-2 gate pulse defines measurement interval
// - Resolution 10 Hz to 1 MHz, decades
// - Gate 200, 20, then 2 ms
// - Gated input clocks two cascaded nibble counters
// - Prescaler MSB clocks timer channel zero
// - Channel-0 overflow raises overflow interrupt
// - Gate end sets done interrupt if acknowledged
// - Low prescaler read strobe drives prescaler bits
// - Timer select and read present timer
package ifc_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 50;
  localparam int IF_HALF_KHZ = 5350;
  localparam logic [2:0] REF_DIV = 3'h5;
  localparam int TB_MHZ = 2;
  localparam int BUS_MHZ = 4;
  localparam int ZS_MIN_SWEEP_MS = 30;
  localparam int GATE_US_10HZ = 200000;
  localparam int GATE_US_100HZ = 20000;
  localparam int GATE_US_1KHZ = 2000;

  // ****************************************
  // Widths and codes
  // ****************************************
  localparam int TICK_W = 20;
  localparam int NIB_W = 4;
  localparam int PRESC_W = 8;
  localparam int TIMER_W = 16;
  localparam int DATA_W = 8;
  localparam logic [2:0] RES_10HZ = 3'h0;
  localparam logic [2:0] RES_100HZ = 3'h1;
  localparam logic [2:0] RES_1KHZ = 3'h2;
  localparam logic [2:0] RES_1MHZ = 3'h5;

  // Synchroniser lanes and their idle levels
  localparam int SY_REF = 0;
  localparam int SY_BUSCLK = 1;
  localparam int SY_COUNT = 2;
  localparam int SY_ACK = 3;
  localparam int SY_PRD_N = 4;
  localparam int SY_TSEL_N = 5;
  localparam int SY_TRD_N = 6;
  localparam int SY_W = 7;
  localparam logic [6:0] SY_RESET = 7'h70;

  typedef enum logic [1:0] {
    IFC_IDLE = 2'b00,
    IFC_CLEAR = 2'b01,
    IFC_GATE = 2'b10
  } ifc_state_type;

endpackage

//--- ifc_presc_if.sv
// Link between the gate controller and the gated eight-bit prescaler.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface ifc_presc_if;
  logic clear;
  logic step;
  logic [ifc_pkg::PRESC_W-1:0] count;
  logic carry;
  modport counter (input clear, input step, output count, output carry);
  modport user (output clear, output step, input count, input carry);
endinterface

//--- ifc_prescaler.sv
// Gated divide-by-256 prescaler built from two cascaded nibble counters.
// Assumes step is a one-cycle pulse per gated input edge.
`timescale 1ns/10ps
module ifc_prescaler (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  ifc_presc_if.counter pif
);

  logic [ifc_pkg::NIB_W-1:0] lo_q, lo_d, hi_q, hi_d;
  logic carry_q, carry_d;

  always_comb begin
    lo_d = lo_q;
    hi_d = hi_q;
    carry_d = 1'b0;
    if (pif.clear) begin
      lo_d = '0;
      hi_d = '0;
    end else if (pif.step) begin
      lo_d = lo_q + 4'h1;
      if (lo_q == 4'hf) begin
        hi_d = hi_q + 4'h1;
        carry_d = (hi_q == 4'hf);
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lo_q <= '0;
      hi_q <= '0;
      carry_q <= 1'b0;
    end else if (ce) begin
      lo_q <= lo_d;
      hi_q <= hi_d;
      carry_q <= carry_d;
    end
  end

  assign pif.count = {hi_q, lo_q};
  assign pif.carry = carry_q;

endmodule // ifc_prescaler
